/* design/mscfg_top.sv */
/*
 * Sample-rate, orientation debounce and tap configuration logic of a three-axis motion sensor.
 * Assumes a serial front end delivers register requests and a sensing cell delivers
 * measurements synchronous to CLOCK; orientation code comes from an outside classifier.
 */
`timescale 1ns/1ps
`default_nettype none

module mscfg_top
    import mscfg_pkg::*;
#(
    parameter int CYC_TAP_MODE = T_TAP_MODE_US * 1000 / CLK_PERIOD_NS,
    parameter int CYC_32HZ = T_32HZ_US * 1000 / CLK_PERIOD_NS,
    parameter int CYC_16HZ = T_16HZ_US * 1000 / CLK_PERIOD_NS,
    parameter int CYC_8HZ = T_8HZ_US * 1000 / CLK_PERIOD_NS,
    parameter int CYC_4HZ = T_4HZ_US * 1000 / CLK_PERIOD_NS,
    parameter int CYC_2HZ = T_2HZ_US * 1000 / CLK_PERIOD_NS,
    parameter int CYC_1HZ = T_1HZ_US * 1000 / CLK_PERIOD_NS
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire mscfg_pkg::mscfg_reg_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    input wire logic CELL_VALID,
    input wire mscfg_pkg::mscfg_accel_t CELL_DATA,
    input wire logic [mscfg_pkg::ORIENT_W-1:0] ORIENT_RAW,
    input wire logic AUTO_WAKE_MODE,
    input wire logic AUTO_SLEEP_EN,
    output logic SAMPLE_READY,
    output logic TAP_EVENT,
    output logic SLEEP_COUNT_RESTART
);
    import mscfg_pkg::*;

    typedef enum logic [0:0] {
        ST_WAIT = 1'b0,
        ST_COLLECT = 1'b1
    } mscfg_state_t;

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] sample_rate_config_q;
    logic [7:0] tap_detect_config_q;
    logic [2:0][ACCEL_W-1:0] accel_out_q;
    logic [ORIENT_W-1:0] tilt_q;

    logic [2:0] active_rate_select;
    logic [1:0] wake_rate_select;
    logic [2:0] orientation_debounce_len;
    logic [4:0] tap_threshold;
    logic [2:0] axis_tap_disable;
    logic tap_mode;

    assign active_rate_select = sample_rate_config_q[ACTIVE_RATE_LSB +: 3];
    assign wake_rate_select = sample_rate_config_q[WAKE_RATE_LSB +: 2];
    assign orientation_debounce_len = sample_rate_config_q[DEBOUNCE_LSB +: 3];
    assign tap_threshold = tap_detect_config_q[TAP_THRESHOLD_LSB +: 5];
    assign axis_tap_disable = {tap_detect_config_q[Z_TAP_DISABLE_BIT],
                               tap_detect_config_q[Y_TAP_DISABLE_BIT],
                               tap_detect_config_q[X_TAP_DISABLE_BIT]};
    // tap mode only from the active rate, never while waking
    assign tap_mode = !AUTO_WAKE_MODE && (active_rate_select == TAP_DETECT_RATE_MODE);

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            sample_rate_config_q <= SAMPLE_RATE_CONFIG_RST;
            tap_detect_config_q <= TAP_DETECT_CONFIG_RST;
        end else if (REG_REQ.wr) begin
            if (REG_REQ.addr == ADDR_SAMPLE_RATE_CONFIG) begin
                sample_rate_config_q <= REG_REQ.wdata;
            end
            if (REG_REQ.addr == ADDR_TAP_DETECT_CONFIG) begin
                tap_detect_config_q <= REG_REQ.wdata;
            end
        end
    end

    // registered read data; unmapped slots read zero, output-only slots read zero above the field
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_REQ.rd) begin
            unique case (REG_REQ.addr)
                ADDR_X_ACCEL_OUTPUT: REG_RDATA <= {2'h0, accel_out_q[0]};
                ADDR_Y_ACCEL_OUTPUT: REG_RDATA <= {2'h0, accel_out_q[1]};
                ADDR_Z_ACCEL_OUTPUT: REG_RDATA <= {2'h0, accel_out_q[2]};
                ADDR_TILT_STATUS: REG_RDATA <= {3'h0, tilt_q};
                ADDR_SAMPLE_RATE_CONFIG: REG_RDATA <= sample_rate_config_q;
                ADDR_TAP_DETECT_CONFIG: REG_RDATA <= tap_detect_config_q;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // sample period
    // ************************************************************
    logic [PERIOD_W-1:0] period_cyc;
    logic [PERIOD_W-1:0] period_cnt_q;
    logic sample_tick;

    // period lookup; active codes 001..100 are not served here and fall back to 1 Hz
    always_comb begin
        period_cyc = PERIOD_W'(CYC_1HZ);
        if (AUTO_WAKE_MODE) begin
            unique case (wake_rate_select)
                WAKE_RATE_32HZ: period_cyc = PERIOD_W'(CYC_32HZ);
                WAKE_RATE_16HZ: period_cyc = PERIOD_W'(CYC_16HZ);
                WAKE_RATE_8HZ: period_cyc = PERIOD_W'(CYC_8HZ);
                WAKE_RATE_1HZ: period_cyc = PERIOD_W'(CYC_1HZ);
            endcase
        end else begin
            unique case (active_rate_select)
                TAP_DETECT_RATE_MODE: period_cyc = PERIOD_W'(CYC_TAP_MODE);
                ACTIVE_RATE_4HZ: period_cyc = PERIOD_W'(CYC_4HZ);
                ACTIVE_RATE_2HZ: period_cyc = PERIOD_W'(CYC_2HZ);
                ACTIVE_RATE_1HZ: period_cyc = PERIOD_W'(CYC_1HZ);
                default: period_cyc = PERIOD_W'(CYC_1HZ);
            endcase
        end
    end

    // free-running period counter; >= compare keeps a shortened period from overrunning
    assign sample_tick = (period_cnt_q >= period_cyc - PERIOD_W'(1));
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            period_cnt_q <= '0;
        end else if (sample_tick) begin
            period_cnt_q <= '0;
        end else begin
            period_cnt_q <= period_cnt_q + PERIOD_W'(1);
        end
    end

    // ************************************************************
    // averaging of 32 measurements
    // ************************************************************
    mscfg_state_t state_q;
    logic [5:0] meas_cnt_q;
    logic [2:0][SUM_W-1:0] sum_q;
    logic avg_done;
    logic [2:0] tap_hit;

    assign avg_done = (state_q == ST_COLLECT) && CELL_VALID && (meas_cnt_q == 6'(MEAS_PER_SAMPLE - 1));

    // a tick while still collecting is ignored: the sample in progress finishes first
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state_q <= ST_WAIT;
            meas_cnt_q <= 6'h00;
        end else begin
            unique case (state_q)
                ST_WAIT: begin
                    if (sample_tick) begin
                        state_q <= ST_COLLECT;
                        meas_cnt_q <= 6'h00;
                    end
                end
                ST_COLLECT: begin
                    if (avg_done) begin
                        state_q <= ST_WAIT;
                    end else if (CELL_VALID) begin
                        meas_cnt_q <= meas_cnt_q + 6'h01;
                    end
                end
            endcase
        end
    end

    genvar ax;
    generate
        for (ax = 0; ax < 3; ax++) begin : g_axis
            always_ff @(posedge CLOCK or negedge NRST) begin
                if (!NRST) begin
                    sum_q[ax] <= '0;
                    accel_out_q[ax] <= '0;
                end else if (state_q == ST_WAIT) begin
                    sum_q[ax] <= '0;
                end else if (CELL_VALID) begin
                    sum_q[ax] <= SUM_W'(sum_q[ax] + {{AVG_SHIFT{CELL_DATA.axis[ax][ACCEL_W-1]}}, CELL_DATA.axis[ax]});
                    if (avg_done) begin
                        accel_out_q[ax] <= ACCEL_W'((sum_q[ax] + {{AVG_SHIFT{CELL_DATA.axis[ax][ACCEL_W-1]}},
                                                      CELL_DATA.axis[ax]}) >> AVG_SHIFT);
                    end
                end
            end

            mscfg_tap_axis u_tap (
                .clk(CLOCK),
                .nrst(NRST),
                .meas_valid(CELL_VALID && tap_mode),
                .value(CELL_DATA.axis[ax]),
                .threshold(tap_threshold),
                .axis_enable(!axis_tap_disable[ax]),
                .hit(tap_hit[ax])
            );
        end
    endgenerate

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            SAMPLE_READY <= 1'b0;
        end else begin
            SAMPLE_READY <= avg_done;
        end
    end

    // ************************************************************
    // orientation debounce
    // ************************************************************
    logic [ORIENT_W-1:0] orient_prev_q;
    logic [2:0] run_q;
    logic [2:0] run_d;

    // a differing sample restarts the run
    always_comb begin
        if (ORIENT_RAW != orient_prev_q) begin
            run_d = 3'h0;
        end else if (run_q != 3'h7) begin
            run_d = run_q + 3'h1;
        end else begin
            run_d = run_q;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            orient_prev_q <= '0;
            run_q <= 3'h0;
            tilt_q <= '0;
        end else if (avg_done) begin
            orient_prev_q <= ORIENT_RAW;
            run_q <= run_d;
            if (run_d >= orientation_debounce_len) begin
                tilt_q <= ORIENT_RAW;
            end
        end
    end

    // ************************************************************
    // tap event
    // ************************************************************
    // tap restarts the inactivity count only with all axes enabled
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            TAP_EVENT <= 1'b0;
            SLEEP_COUNT_RESTART <= 1'b0;
        end else begin
            TAP_EVENT <= |tap_hit;
            SLEEP_COUNT_RESTART <= (|tap_hit) && (axis_tap_disable == 3'h0) && tap_mode && AUTO_SLEEP_EN;
        end
    end
endmodule : mscfg_top
`default_nettype wire

/* design/mscfg_pkg.sv */
/*
 * Shared constants and types of the motion sample-rate and tap configuration block.
 * Assumes a single 100 MHz clock; all timing figures are derived from CLK_PERIOD_NS.
 */
`default_nettype none
package mscfg_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_X_ACCEL_OUTPUT = 8'h00;
    localparam logic [7:0] ADDR_Y_ACCEL_OUTPUT = 8'h01;
    localparam logic [7:0] ADDR_Z_ACCEL_OUTPUT = 8'h02;
    localparam logic [7:0] ADDR_TILT_STATUS = 8'h03;
    localparam logic [7:0] ADDR_SAMPLE_RATE_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_TAP_DETECT_CONFIG = 8'h09;
    localparam logic [7:0] SAMPLE_RATE_CONFIG_RST = 8'h00;
    localparam logic [7:0] TAP_DETECT_CONFIG_RST = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ACTIVE_RATE_LSB = 0;
    localparam int WAKE_RATE_LSB = 3;
    localparam int DEBOUNCE_LSB = 5;
    localparam int TAP_THRESHOLD_LSB = 0;
    localparam int X_TAP_DISABLE_BIT = 5;
    localparam int Y_TAP_DISABLE_BIT = 6;
    localparam int Z_TAP_DISABLE_BIT = 7;

    // ************************************************************
    // rate codes
    // ************************************************************
    localparam logic [2:0] TAP_DETECT_RATE_MODE = 3'h0;
    localparam logic [2:0] ACTIVE_RATE_4HZ = 3'h5;
    localparam logic [2:0] ACTIVE_RATE_2HZ = 3'h6;
    localparam logic [2:0] ACTIVE_RATE_1HZ = 3'h7;
    localparam logic [1:0] WAKE_RATE_32HZ = 2'h0;
    localparam logic [1:0] WAKE_RATE_16HZ = 2'h1;
    localparam logic [1:0] WAKE_RATE_8HZ = 2'h2;
    localparam logic [1:0] WAKE_RATE_1HZ = 2'h3;

    // ************************************************************
    // timing, sample periods in microseconds, clock period in nanoseconds
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_TAP_MODE_US = 8360;
    localparam int T_32HZ_US = 31250;
    localparam int T_16HZ_US = 62500;
    localparam int T_8HZ_US = 125000;
    localparam int T_4HZ_US = 250000;
    localparam int T_2HZ_US = 500000;
    localparam int T_1HZ_US = 1000000;
    localparam int MEAS_PER_SAMPLE = 32;
    localparam int AVG_SHIFT = 5;

    // ************************************************************
    // widths and carriers
    // ************************************************************
    localparam int ACCEL_W = 6;
    localparam int SUM_W = ACCEL_W + AVG_SHIFT;
    localparam int ORIENT_W = 5;
    localparam int PERIOD_W = 27;

    typedef struct packed {
        logic [2:0][ACCEL_W-1:0] axis; // index 0 = x, 1 = y, 2 = z, signed
    } mscfg_accel_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } mscfg_reg_req_t;

endpackage : mscfg_pkg
`default_nettype wire

/* design/mscfg_tap_axis.sv */
/*
 * One axis of tap detection: fast and slow filtered responses, threshold compare.
 * Assumes meas_valid pulses once per sensing-cell measurement, value signed.
 */
`timescale 1ns/1ps
`default_nettype none
module mscfg_tap_axis (
    input wire logic clk,
    input wire logic nrst,
    input wire logic meas_valid,
    input wire logic [5:0] value,
    input wire logic [4:0] threshold,
    input wire logic axis_enable,
    output logic hit
);
    logic signed [5:0] prev_q;
    logic signed [9:0] slow_q;
    logic signed [6:0] fast;
    logic signed [9:0] slow_step;
    logic signed [6:0] delta;
    logic [6:0] abs_delta;

    // fast response: rolling mean of current and last measurement
    assign fast = 7'(($signed(value) + prev_q) >>> 1);
    // slow response: first-order lag with three fraction bits
    assign slow_step = 10'(($signed({value, 3'h0}) - slow_q) >>> 3);
    assign delta = 7'(fast - 7'(slow_q >>> 3));
    assign abs_delta = delta[6] ? 7'(-delta) : delta;

    // filters advance only on a new measurement
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_q <= 6'sh00;
            slow_q <= 10'sh000;
        end else if (meas_valid) begin
            prev_q <= $signed(value);
            slow_q <= 10'(slow_q + slow_step);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hit <= 1'b0;
        end else begin
            hit <= meas_valid && axis_enable && (abs_delta > {2'h0, threshold});
        end
    end
endmodule : mscfg_tap_axis
`default_nettype wire

/* testbench/mscfg_top_asserts.sv */
/*
 * Port checker of the sample-rate and tap block.
 * Assumes it is bound onto mscfg_top; one clock, async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module mscfg_top_asserts
    import mscfg_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire mscfg_pkg::mscfg_reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic CELL_VALID,
    input wire mscfg_pkg::mscfg_accel_t CELL_DATA,
    input wire logic [mscfg_pkg::ORIENT_W-1:0] ORIENT_RAW,
    input wire logic AUTO_WAKE_MODE,
    input wire logic AUTO_SLEEP_EN,
    input wire logic SAMPLE_READY,
    input wire logic TAP_EVENT,
    input wire logic SLEEP_COUNT_RESTART
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    logic [7:0] rate_q;
    logic [7:0] tap_q;
    // shadow of the writable registers, so reads can be judged without the body
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rate_q <= 8'h00;
            tap_q <= 8'h00;
        end else if (REG_REQ.wr && REG_REQ.addr == ADDR_SAMPLE_RATE_CONFIG) begin
            rate_q <= REG_REQ.wdata;
        end else if (REG_REQ.wr && REG_REQ.addr == ADDR_TAP_DETECT_CONFIG) begin
            tap_q <= REG_REQ.wdata;
        end
    end
    chk_ready_single: assert property (SAMPLE_READY |=> !SAMPLE_READY)
        else $error("sample ready longer than one cycle");
    chk_ready_cause: assert property (SAMPLE_READY |-> $past(CELL_VALID) || $past(CELL_VALID, 2))
        else $error("sample ready without a measurement");
    chk_tap_cause: assert property (TAP_EVENT |-> $past(CELL_VALID, 2))
        else $error("tap event not two cycles after a measurement");
    chk_tap_wake_off: assert property ($past(AUTO_WAKE_MODE, 2) && $past(AUTO_WAKE_MODE) |-> !TAP_EVENT)
        else $error("tap event outside tap mode");
    chk_restart_cfg: assert property (SLEEP_COUNT_RESTART |-> tap_q[7:5] == 3'h0
        && rate_q[2:0] == TAP_DETECT_RATE_MODE && $past(AUTO_SLEEP_EN))
        else $error("sleep restart with wrong configuration");
    chk_rdata_hold: assert property (!$past(REG_REQ.rd) |-> $stable(REG_RDATA))
        else $error("read data changed without a read");
    chk_read_rate: assert property (REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == ADDR_SAMPLE_RATE_CONFIG
        |=> REG_RDATA == rate_q)
        else $error("rate register read mismatch");
    chk_read_tap: assert property (REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == ADDR_TAP_DETECT_CONFIG
        |=> REG_RDATA == tap_q)
        else $error("tap register read mismatch");
    chk_read_unmapped: assert property (REG_REQ.rd && REG_REQ.addr > 8'h09 |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    cov_sample: cover property (SAMPLE_READY);
    cov_tap: cover property (TAP_EVENT);
    cov_restart: cover property (SLEEP_COUNT_RESTART);
endmodule : mscfg_top_asserts
bind mscfg_top mscfg_top_asserts chk_u (.CLOCK, .NRST, .REG_REQ, .REG_RDATA, .CELL_VALID, .CELL_DATA,
    .ORIENT_RAW, .AUTO_WAKE_MODE, .AUTO_SLEEP_EN, .SAMPLE_READY, .TAP_EVENT, .SLEEP_COUNT_RESTART);
`default_nettype wire

/* testbench/mscfg_host_model.sv */
/*
 * Host model: issues single register writes and reads on the request port.
 * Assumes requests are taken on the rising clock and read data lands one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module mscfg_host_model
    import mscfg_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    output var mscfg_pkg::mscfg_reg_req_t req
);
    initial req = '0;
    // write: request stands for exactly the one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask : wr
    // read: data is settled by the falling edge after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        d = rdata;
    endtask : rd
endmodule : mscfg_host_model
`default_nettype wire

/* testbench/mscfg_tb_top.sv */
/*
 * Self-checking bench of the sample-rate, debounce and tap block.
 * Assumes short period parameters; cell data arrives every cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mscfg_tb_top;
    import mscfg_pkg::*;
    // ************************************************************
    // shortened periods keep the run brief
    // ************************************************************
    localparam int P_TAP = 100, P_32 = 110, P_16 = 120, P_8 = 130, P_4 = 140, P_2 = 150, P_1 = 160;
    logic clock = 0, nrst = 0, cell_valid = 0, auto_wake = 0, sleep_en = 0, phase = 0;
    logic ready, tap, restart, seen_tap, seen_rst;
    logic [7:0] rdata;
    logic [4:0] orient = 5'h00;
    logic [17:0] pat_a = {6'h1e, 6'h3e, 6'h04}, pat_b = {6'h22, 6'h3a, 6'h06};
    mscfg_reg_req_t req;
    mscfg_accel_t cell_data = '0;
    int n_fail = 0, cmp_count = 0;
    always #5 clock = ~clock;
    mscfg_host_model host_u (.clk(clock), .rdata(rdata), .req(req));
    mscfg_top #(.CYC_TAP_MODE(P_TAP), .CYC_32HZ(P_32), .CYC_16HZ(P_16), .CYC_8HZ(P_8),
        .CYC_4HZ(P_4), .CYC_2HZ(P_2), .CYC_1HZ(P_1)) dut_u (.CLOCK(clock), .NRST(nrst),
        .REG_REQ(req), .REG_RDATA(rdata), .CELL_VALID(cell_valid), .CELL_DATA(cell_data),
        .ORIENT_RAW(orient), .AUTO_WAKE_MODE(auto_wake), .AUTO_SLEEP_EN(sleep_en),
        .SAMPLE_READY(ready), .TAP_EVENT(tap), .SLEEP_COUNT_RESTART(restart));
    // cell feed: alternating sets make the mean differ from either set
    always @(posedge clock) begin
        phase <= !phase;
        cell_valid <= nrst;
        cell_data <= phase ? pat_b : pat_a;
    end
    // pulses are caught mid-cycle so none slips between checks
    always @(negedge clock) begin
        if (tap === 1'b1) seen_tap = 1'b1;
        if (restart === 1'b1) seen_rst = 1'b1;
    end
    task automatic wait_ready(output int gap);
        gap = 0;
        do begin
            @(negedge clock);
            gap++;
        end while (ready !== 1'b1 && gap < 1000);
        `CHK(ready, 1'b1)
    endtask : wait_ready
    task automatic t_regs();
        logic [7:0] d;
        host_u.rd(ADDR_TAP_DETECT_CONFIG, d);
        `CHK(d, TAP_DETECT_CONFIG_RST)
        host_u.rd(8'h20, d);
        `CHK(d, 8'h00)
        host_u.wr(ADDR_TAP_DETECT_CONFIG, 8'hb5);
        host_u.rd(ADDR_TAP_DETECT_CONFIG, d);
        `CHK(d, 8'hb5)
    endtask : t_regs
    task automatic t_rates();
        logic [7:0] code [8] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h05, 8'h0d, 8'h15, 8'h1d};
        int per [8] = '{P_TAP, P_4, P_2, P_1, P_32, P_16, P_8, P_1};
        int g;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            auto_wake <= (i >= 4);
            host_u.wr(ADDR_SAMPLE_RATE_CONFIG, code[i]);
            repeat (3) wait_ready(g);
            `CHK(g, per[i])
        end
        auto_wake <= 1'b0;
    endtask : t_rates
    task automatic t_accel();
        logic [7:0] d;
        int g;
        wait_ready(g);
        host_u.rd(ADDR_X_ACCEL_OUTPUT, d);
        `CHK(d, 8'h05)
        host_u.rd(ADDR_Y_ACCEL_OUTPUT, d);
        `CHK(d, 8'h3c)
        host_u.rd(ADDR_Z_ACCEL_OUTPUT, d);
        `CHK(d, 8'h00)
    endtask : t_accel
    task automatic feed(input logic [4:0] c, input int n);
        int g;
        repeat (n) begin
            @(posedge clock);
            orient <= c;
            // a sample closing on this very edge still saw the old code; skip it
            do wait_ready(g); while (g == 1);
        end
    endtask : feed
    task automatic t_debounce(input logic [2:0] n);
        logic [7:0] d;
        host_u.wr(ADDR_SAMPLE_RATE_CONFIG, 8'h00);
        feed(5'h0a, 2);
        host_u.rd(ADDR_TILT_STATUS, d);
        `CHK(d, 8'h0a)
        host_u.wr(ADDR_SAMPLE_RATE_CONFIG, {n, 5'h00});
        feed(5'h11, n);
        feed(5'h05, 1);
        feed(5'h11, n);
        host_u.rd(ADDR_TILT_STATUS, d);
        `CHK(d, 8'h0a)
        feed(5'h11, 1);
        host_u.rd(ADDR_TILT_STATUS, d);
        `CHK(d, 8'h11)
    endtask : t_debounce
    task automatic t_tap(input logic [7:0] cfg, input logic [17:0] step, input logic en, input logic et,
        input logic er);
        host_u.wr(ADDR_TAP_DETECT_CONFIG, cfg);
        @(posedge clock);
        sleep_en <= en;
        pat_a <= '0;
        pat_b <= '0;
        repeat (60) @(posedge clock);
        seen_tap = 1'b0;
        seen_rst = 1'b0;
        pat_a <= step;
        pat_b <= step;
        repeat (20) @(posedge clock);
        `CHK(seen_tap, et)
        `CHK(seen_rst, er)
    endtask : t_tap
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_rates();
        t_accel();
        t_debounce(3'h1);
        t_debounce(3'h7);
        t_tap(8'h05, 18'h00014, 1'b1, 1'b1, 1'b1);
        t_tap(8'h25, 18'h00014, 1'b1, 1'b0, 1'b0);
        t_tap(8'h25, 18'h00500, 1'b1, 1'b1, 1'b0);
        t_tap(8'h1f, 18'h00014, 1'b1, 1'b0, 1'b0);
        t_tap(8'hc5, 18'h00014, 1'b0, 1'b1, 1'b0);
        t_tap(8'h85, 18'h14000, 1'b1, 1'b0, 1'b0);
        t_tap(8'h45, 18'h14000, 1'b1, 1'b1, 1'b0);
        t_tap(8'h05, 18'h00014, 1'b0, 1'b1, 1'b0);
        end_of_test();
    end
    // watchdog: well beyond the roughly six thousand cycles the run needs
    initial begin
        #(60000 * 10);
        n_fail++;
        end_of_test();
    end
endmodule : mscfg_tb_top
`default_nettype wire
